//--- tcc_cfg.svh
// register offsets, field positions and reset values of the channel block
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
`define TCC_IDX_SC0      8'h25
`define TCC_IDX_VH0      8'h26
`define TCC_IDX_VL0      8'h27
`define TCC_IDX_SC1      8'h28
`define TCC_IDX_VH1      8'h29
`define TCC_IDX_VL1      8'h2a
`define TCC_ADDR_W       12
`define TCC_BIT_FLAG     7
`define TCC_BIT_IE       6
`define TCC_BIT_MSB      5
`define TCC_BIT_MSA      4
`define TCC_BIT_ELSH     3
`define TCC_BIT_ELSL     2
`define TCC_BIT_TOV      1
`define TCC_BIT_MAX      0
`define TCC_SC_RESET     8'h00
`define TCC_ELS_OFF      2'b00
`define TCC_ELS_RISE     2'b01
`define TCC_ELS_FALL     2'b10
`define TCC_ELS_ANY      2'b11
`endif

//--- tcc_pkg.sv
// types shared by the timer channel block
package tcc_pkg;
    typedef enum logic [3:0] {
        TCC_MODE_OFF = 4'b0001,
        TCC_MODE_CAP = 4'b0010,
        TCC_MODE_CMP = 4'b0100,
        TCC_MODE_BUF = 4'b1000
    } tcc_mode_type;
endpackage : tcc_pkg

//--- tcc_capture_compare.sv
// two-channel timer capture/compare logic with an apb register slave
`timescale 1ns/1ps
`include "tcc_cfg.svh"

module tcc_capture_compare
    import tcc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] counter_value,
    input  wire logic        counter_overflow,
    input  wire logic        timer_tick,
    input  wire logic [1:0]  channel_pin_in,
    output logic [1:0]       channel_pin_out,
    output logic [1:0]       channel_pin_oe_n,
    output logic [1:0]       channel_irq
);

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic        acc;
    logic        wr_acc;
    logic        rd_acc;
    logic [9:0]  widx;
    logic        idx_ok;
    assign acc    = psel & penable;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;
    assign widx   = paddr[11:2];
    assign idx_ok = (paddr[1:0] == 2'b00) &&
                    (widx >= {2'b00, `TCC_IDX_SC0}) &&
                    (widx <= {2'b00, `TCC_IDX_VL1});
    assign pready  = 1'b1;                 // zero wait states
    assign pslverr = acc & ~idx_ok;

    // register hit for channel c, slot s (0 sc, 1 high, 2 low)
    function automatic logic hit(input logic [9:0] i, input int c,
                                 input int s);
        logic [7:0] base;
        base = (c == 0) ? `TCC_IDX_SC0 : `TCC_IDX_SC1;
        hit  = (i == {2'b00, base + 8'(s)});
    endfunction : hit

    // ****************************************************************
    // per-channel state
    // ****************************************************************
    logic [7:0]  sc_r     [2];
    logic [15:0] val_r    [2];
    logic [1:0]  armed_r;                  // flag seen set by a read
    logic [1:0]  cap_lock_r;
    logic [1:0]  cmp_lock_r;
    logic [1:0]  out_r;
    logic [1:0]  max_act_r;                // max duty, period aligned
    logic [1:0]  event_w;
    logic [1:0]  pin_s1_r, pin_s2_r, pin_s3_r;
    logic [7:0]  buf_hi_r [2];             // staged compare high byte
    tcc_mode_type mode_w [2];

    logic        link_w;
    assign link_w = sc_r[0][`TCC_BIT_MSB];

    // three-stage pin synchroniser; s2/s3 compared for edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_r <= 2'b00;
            pin_s2_r <= 2'b00;
            pin_s3_r <= 2'b00;
        end else begin
            pin_s1_r <= channel_pin_in;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            logic [1:0] els;
            logic       msa;
            logic       is_cap, is_cmp, rise, fall, edge_hit;
            logic       match, tov, ovf_act, cmp_act;
            logic       rd_sc, wr_sc, rd_hi, rd_lo, wr_hi, wr_lo;
            logic       clr_ok, out_nxt, disabled;
            assign disabled = (c == 1) && link_w;
            assign els = sc_r[c][`TCC_BIT_ELSH:`TCC_BIT_ELSL];
            assign msa = sc_r[c][`TCC_BIT_MSA];
            // mode decode, buffered only exists on channel 0
            assign mode_w[c] = disabled ? TCC_MODE_OFF :
                (els == `TCC_ELS_OFF) ? TCC_MODE_OFF :
                ((c == 0) && link_w) ? TCC_MODE_BUF :
                msa ? TCC_MODE_CMP : TCC_MODE_CAP;
            assign is_cap = (mode_w[c] == TCC_MODE_CAP);
            assign is_cmp = (mode_w[c] == TCC_MODE_CMP) ||
                            (mode_w[c] == TCC_MODE_BUF);
            assign rise = pin_s2_r[c] & ~pin_s3_r[c];
            assign fall = ~pin_s2_r[c] & pin_s3_r[c];
            assign edge_hit = (els == `TCC_ELS_RISE) ? rise :
                              (els == `TCC_ELS_FALL) ? fall :
                              (rise | fall);
            // buffered mode reuses channel 0 value as the shared compare
            assign match = timer_tick & (counter_value == val_r[c]) &
                           ~cmp_lock_r[c];
            assign tov   = sc_r[c][`TCC_BIT_TOV];
            assign ovf_act = is_cmp & tov & counter_overflow;
            assign cmp_act = is_cmp & match & ~ovf_act;
            // a capture only counts on a timer tick, as the stored value
            assign event_w[c] = (is_cap & timer_tick & edge_hit &
                                 ~cap_lock_r[c])
                              | (is_cmp & match);
            assign rd_sc = rd_acc & hit(widx, c, 0) & ~disabled;
            assign wr_sc = wr_acc & hit(widx, c, 0) & ~disabled;
            assign rd_hi = rd_acc & hit(widx, c, 1);
            assign rd_lo = rd_acc & hit(widx, c, 2);
            assign wr_hi = wr_acc & hit(widx, c, 1);
            assign wr_lo = wr_acc & hit(widx, c, 2);
            // clear needs arming read, a 0 write and no fresh event
            assign clr_ok = wr_sc & armed_r[c] &
                            ~pwdata[`TCC_BIT_FLAG] & ~event_w[c];

            // output level: preset when off, else overflow/compare action
            always_comb begin
                out_nxt = out_r[c];
                if (mode_w[c] == TCC_MODE_OFF) begin
                    out_nxt = ~msa;
                end else if (ovf_act) begin
                    out_nxt = max_act_r[c] ? 1'b1 : ~out_r[c];
                end else if (cmp_act && !max_act_r[c]) begin
                    unique case (els)
                        `TCC_ELS_RISE: out_nxt = ~out_r[c];
                        `TCC_ELS_FALL: out_nxt = 1'b0;
                        default:       out_nxt = 1'b1;
                    endcase
                end
            end

            // control/status register, flag and arming
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sc_r[c]    <= `TCC_SC_RESET;
                    armed_r[c] <= 1'b0;
                end else begin
                    if (wr_sc) begin
                        sc_r[c][6:0] <= (c == 0) ? pwdata[6:0]
                            : {pwdata[6], 1'b0, pwdata[4:0]};
                    end
                    if (event_w[c])
                        sc_r[c][`TCC_BIT_FLAG] <= 1'b1;
                    else if (clr_ok)
                        sc_r[c][`TCC_BIT_FLAG] <= 1'b0;
                    // a fresh event disarms, so a stale clear cannot land
                    if (event_w[c])
                        armed_r[c] <= 1'b0;
                    else if (rd_sc && sc_r[c][`TCC_BIT_FLAG])
                        armed_r[c] <= 1'b1;
                    else if (wr_sc || !sc_r[c][`TCC_BIT_FLAG])
                        armed_r[c] <= 1'b0;
                end
            end

            // byte locks of the value pair and pwm output state
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cap_lock_r[c] <= 1'b0;
                    cmp_lock_r[c] <= 1'b0;
                    out_r[c]      <= 1'b1;
                    max_act_r[c]  <= 1'b0;
                end else begin
                    if (rd_hi && is_cap) cap_lock_r[c] <= 1'b1;
                    else if (rd_lo)      cap_lock_r[c] <= 1'b0;
                    if (wr_hi && !is_cap) cmp_lock_r[c] <= 1'b1;
                    else if (wr_lo)       cmp_lock_r[c] <= 1'b0;
                    out_r[c] <= out_nxt;
                    if (counter_overflow || mode_w[c] == TCC_MODE_OFF)
                        max_act_r[c] <= sc_r[c][`TCC_BIT_MAX] &
                                        tov;
                end
            end

            // data storage without reset
            always_ff @(posedge pclk) begin
                if (is_cap && timer_tick && edge_hit && !cap_lock_r[c])
                    val_r[c] <= counter_value;
                else if (wr_lo)
                    val_r[c] <= {buf_hi_r[c], pwdata[7:0]};
                if (wr_hi)
                    buf_hi_r[c] <= pwdata[7:0];
            end

            assign channel_irq[c] = sc_r[c][`TCC_BIT_FLAG] &
                                    sc_r[c][`TCC_BIT_IE];
            assign channel_pin_out[c]  = (c == 1) ? out_r[c] :
                                          out_r[c];
            assign channel_pin_oe_n[c] = ~is_cmp;
        end
    endgenerate

    // ****************************************************************
    // read data mux
    // ****************************************************************
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit(widx, 0, 0)) rd_byte = sc_r[0];
        if (hit(widx, 0, 1)) rd_byte = val_r[0][15:8];
        if (hit(widx, 0, 2)) rd_byte = val_r[0][7:0];
        if (hit(widx, 1, 0)) rd_byte = link_w ? 8'h00 : sc_r[1];
        if (hit(widx, 1, 1)) rd_byte = val_r[1][15:8];
        if (hit(widx, 1, 2)) rd_byte = val_r[1][7:0];
    end
    assign prdata = {24'h000000, rd_byte};

endmodule : tcc_capture_compare

//--- tcc_checker.sv
// concurrent checks on the ports of the timer channel block
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_checker
    import tcc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] counter_value,
    input wire logic        counter_overflow,
    input wire logic        timer_tick,
    input wire logic [1:0]  channel_pin_in,
    input wire logic [1:0]  channel_pin_out,
    input wire logic [1:0]  channel_pin_oe_n,
    input wire logic [1:0]  channel_irq
);
    // access decode; only events or bus writes may move the request line
    wire acc    = psel && penable;
    wire wr_acc = acc && pwrite;
    wire cause  = timer_tick || wr_acc;
    wire mapped = paddr inside {`TCC_IDX_SC0 * 4, `TCC_IDX_VH0 * 4,
        `TCC_IDX_VL0 * 4, `TCC_IDX_SC1 * 4, `TCC_IDX_VH1 * 4, `TCC_IDX_VL1 * 4};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // status read of channel 0, the reference for pin ownership
    sequence rd_sc0;
        acc && !pwrite && paddr == `TCC_IDX_SC0 * 4;
    endsequence
    a_ready_now: assert property (acc |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("no error on unmapped address");
    a_irq_is_flag: assert property (
        rd_sc0 |-> channel_irq[0] == (prdata[7] && prdata[6]))
        else $error("request differs from flag and enable");
    a_off_frees_pin: assert property (
        rd_sc0 ##0 prdata[3:2] == 2'b00 |-> channel_pin_oe_n[0])
        else $error("pin driven with edge field clear");
    a_capture_no_drive: assert property (
        rd_sc0 ##0 prdata[5:4] == 2'b00 && prdata[3:2] != 2'b00
        |-> channel_pin_oe_n[0]) else $error("capture channel drives pin");
    a_compare_drives: assert property (
        rd_sc0 ##0 prdata[4] && prdata[3:2] != 2'b00
        |-> !channel_pin_oe_n[0]) else $error("compare channel not driving");
    a_link_frees_pin: assert property (
        rd_sc0 ##0 prdata[5] |-> channel_pin_oe_n[1])
        else $error("linked channel 1 still drives pin");
    a_flag_on_tick: assert property (
        $rose(channel_irq[0]) |-> $past(cause))
        else $error("request rose without tick or write");
    a_irq_fall_write: assert property (
        $fell(channel_irq[0]) |-> $past(wr_acc))
        else $error("request fell without a write");
endmodule : tcc_checker

//--- tcc_pin_model.sv
// far side of the channel pins: outside source or the block's output
`timescale 1ns/1ps
module tcc_pin_model
    import tcc_pkg::*;
(
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe_n,
    input  wire logic [1:0] ext_level,
    output logic [1:0]      pin_level
);
    // block wins where it drives; the source is only moved when settled
    assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule : tcc_pin_model

//--- test_timer_channel_capture_compare.sv
// self-checking bench for the timer channel block
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module test_timer_channel_capture_compare;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        run, tick, ovf, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] cnt;
    logic [7:0]  q;
    logic [1:0]  ext, pin, pout, oe_n, irq;
    int          mismatches = 0, checked = 0, cycles = 0;
    localparam logic [11:0] sc0 = 12'(`TCC_IDX_SC0 * 4);
    localparam logic [11:0] hi0 = 12'(`TCC_IDX_VH0 * 4);
    localparam logic [11:0] lo0 = 12'(`TCC_IDX_VL0 * 4);
    localparam logic [11:0] sc1 = 12'(`TCC_IDX_SC1 * 4);
    tcc_capture_compare uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .counter_value(cnt),
        .counter_overflow(ovf), .timer_tick(tick), .channel_pin_in(pin),
        .channel_pin_out(pout), .channel_pin_oe_n(oe_n), .channel_irq(irq));
    tcc_pin_model far (.pin_out(pout), .pin_oe_n(oe_n), .ext_level(ext),
        .pin_level(pin));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // counter stand-in and hang guard; modulo kept short for quick periods
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
        ovf <= run && cnt == 16'h003e;
        if (run) cnt <= (cnt == 16'h003f) ? 16'h0000 : cnt + 16'h0001;
    end
    // one apb transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {3'b101 & {2'b11, w}, a,
            24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata[7:0];
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task chk(input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                want);
        end
    endtask : chk
    task rd(input logic [11:0] a, input logic [7:0] want);
        apb(1'b0, a, 8'h00);
        chk(q, want);
    endtask : rd
    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr
    // pin edge, then enough cycles for the synchroniser and a tick
    task pin0(input logic v);
        ext[0] <= v;
        repeat (8) @(posedge pclk);
    endtask : pin0
    task stop_test;
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        {psel, penable, pwrite, run, ovf, presetn, paddr, pwdata} = '0;
        {cnt, ext, tick} = {16'h1234, 2'b00, 1'b1};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(sc0, `TCC_SC_RESET);
        apb(1'b0, 12'hffc, 8'h00);
        chk({7'h00, e}, 8'h01);
        // each capture edge choice; counter parked so the value is known
        for (int m = 1; m < 4; m++) begin
            wr(sc0, {4'h4, m[1:0], 2'b00});
            pin0(1'b1);
            rd(sc0, {m[0], 3'b100, m[1:0], 2'b00});
            wr(sc0, {4'h4, m[1:0], 2'b00});
            pin0(1'b0);
            rd(sc0, {m[1], 3'b100, m[1:0], 2'b00});
        end
        rd(hi0, 8'h12);
        rd(lo0, 8'h34);
        wr(sc0, 8'h4c);
        rd(sc0, 8'h4c);
        pin0(1'b1);
        wr(sc0, 8'h4c);
        rd(sc0, 8'hcc);
        pin0(1'b0);
        wr(sc0, 8'h4c);
        rd(sc0, 8'hcc);
        wr(sc0, 8'h4c);
        wr(sc0, 8'hcc);
        rd(sc0, 8'h4c);
        tick <= 1'b0;
        pin0(1'b1);
        rd(sc0, 8'h4c);
        tick <= 1'b1;
        // compare actions from a low preset; counter halted before changes
        for (int m = 1; m < 4; m++) begin
            run <= 1'b0;
            wr(sc0, 8'h10);
            cnt <= 16'h0000;
            wr(hi0, 8'h00);
            wr(lo0, 8'h10);
            wr(sc0, {4'h5, m[1:0], 2'b00});
            run <= 1'b1;
            for (int i = 0; i < 200 && irq[0] !== 1'b1; i++) @(posedge pclk);
            repeat (2) @(posedge pclk);
            chk({6'h00, oe_n[0], pout[0]}, {7'h00, m[0]});
            rd(sc0, {4'hd, m[1:0], 2'b00});
        end
        rd(lo0, 8'h10);
        run <= 1'b0;
        wr(sc1, 8'h54);
        wr(sc0, 8'h20);
        rd(sc1, 8'h00);
        chk({6'h00, oe_n}, 8'h03);
        stop_test();
    end
endmodule : test_timer_channel_capture_compare
bind tcc_capture_compare tcc_checker chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter_value(counter_value),
    .counter_overflow(counter_overflow), .timer_tick(timer_tick),
    .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
    .channel_pin_oe_n(channel_pin_oe_n), .channel_irq(channel_irq));
